//--- bench/aps_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
module aps_axis_model
	import aps_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire aps_valve_type valve_in,
	input wire logic follow_in,
	input wire logic cut_in,
	input wire logic loop_in,
	input wire logic load_in,
	input wire logic [15:0] pos_in,
	output logic [15:0] feedback_raw_out
);
	logic [15:0] pos_q;
	logic [31:0] loop_code;

	// Plant integrates every clock, so one tick of command moves cmd steps
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in || load_in)
			pos_q <= pos_in;
		else if (follow_in && valve_in.active)
			pos_q <= pos_q + 16'($signed(valve_in.command) >>> 3);
	end

	// Loop transmitter spans 4..20 mA; a cut wire reads zero
	assign loop_code = 32'(APS_LOOP_OFFSET) + 32'(pos_q) * 32'h4 / 32'h5;
	assign feedback_raw_out = cut_in ? 16'h0000 :
		loop_in ? loop_code[15:0] : pos_q;
endmodule : aps_axis_model
`default_nettype wire

//--- bench/tb_aps_axis_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_aps_axis_sequencer
	import aps_pkg::*;
;
	// Short tick keeps the run small
	localparam int TICK = 8;
	logic clk, rst_b, ce, en, run, jf, jr, follow, cut, loop, load;
	logic [15:0] tgt, spd, pos, fb_raw;
	logic ready_led, inpos_led;
	aps_cfg_type cfg;
	aps_valve_type valve;
	aps_status_type status;
	int checks, fail_count, i;

	aps_axis_sequencer #(.TICK_CYCLES(TICK)) i_aps_axis_sequencer (
		.clk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .enable_in(en),
		.run_in(run), .jog_fwd_in(jf), .jog_rev_in(jr),
		.target_raw_in(tgt), .feedback_raw_in(fb_raw),
		.speed_raw_in(spd), .cfg_in(cfg), .valve_out(valve),
		.status_out(status), .ready_led_out(ready_led),
		.inpos_led_out(inpos_led));

	aps_axis_model i_aps_axis_model (
		.clk_in(clk), .rst_b_in(rst_b), .valve_in(valve),
		.follow_in(follow), .cut_in(cut), .loop_in(loop),
		.load_in(load), .pos_in(pos), .feedback_raw_out(fb_raw));

	task automatic check(input string n, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
		end
	endtask : check

	task automatic expect_out(input logic r, input logic p, input logic a,
		input logic [15:0] c);
		check("ready", status.ready, r);
		check("inpos", status.inpos, p);
		check("active", valve.active, a);
		check("command", valve.command, c);
		check("ready_led", ready_led, r);
		check("inpos_led", inpos_led, p);
	endtask : expect_out

	// Two ticks: any input change is surely taken and shown
	task automatic settle(input logic r, input logic p, input logic a,
		input logic [15:0] c);
		repeat (2 * TICK) @(negedge clk);
		expect_out(r, p, a, c);
	endtask : settle

	task automatic load_pos(input logic [15:0] v);
		pos = v;
		load = 1'h1;
		@(negedge clk);
		load = 1'h0;
	endtask : load_pos

	task automatic conclude;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		conclude();
	end

	initial
	begin
		checks = 0;
		fail_count = 0;
		{ce, en, run, jf, jr, follow, cut, loop, load} = 9'h100;
		rst_b = 1'h0;
		tgt = 16'h0000;
		spd = 16'h0000;
		pos = 16'h1000;
		cfg = '{16'h0010, 15'h0080, 15'h4000, 1'h0, 16'h0008, 8'h10, 3'h0,
			APS_OUT_V_POS, 1'h0, 16'h1234};
		repeat (4) @(negedge clk);
		rst_b = 1'h1;
		expect_out(1'h0, 1'h0, 1'h0, 16'h0000);
		$display("test reset done");
		en = 1'h1;
		i = 0;
		while (status.ready !== 1'h1 && i < 40)
		begin
			@(negedge clk);
			i++;
		end
		expect_out(1'h1, 1'h0, 1'h1, 16'h0000);
		run = 1'h1;
		tgt = 16'h1008;
		// Just after a tick: nothing may move until the next one
		repeat (TICK - 1)
		begin
			@(negedge clk);
			check("held", status.inpos, 1'h0);
		end
		@(negedge clk);
		expect_out(1'h1, 1'h1, 1'h1, 16'h0008);
		for (i = 0; i < 3; i++)
		begin
			tgt = 16'h1010 + 16'(i);
			settle(1'h1, i == 0, 1'h1, tgt - 16'h1000);
		end
		for (i = 0; i < 2; i++)
		begin
			tgt = 16'h0FF0 - 16'(i);
			settle(1'h1, i == 0, 1'h1, tgt - 16'h1000);
		end
		tgt = 16'h1800;
		cfg.use_ext_speed = 1'h1;
		spd = 16'h0200;
		settle(1'h1, 1'h0, 1'h1, 16'h0100);
		cfg.use_ext_speed = 1'h0;
		cfg.max_velocity = 15'h0200;
		settle(1'h1, 1'h0, 1'h1, 16'h0200);
		cfg.max_velocity = 15'h4000;
		$display("test run done");
		tgt = 16'h1100;
		for (i = 3; i >= 0; i--)
		begin
			cfg.out_sel = aps_out_sel_type'(i);
			settle(1'h1, 1'h0, 1'h1, i[0] ? 16'hFF00 : 16'h0100);
			check("current", valve.current_mode, i[1]);
		end
		run = 1'h0;
		settle(1'h1, 1'h0, 1'h1, 16'h0008);
		run = 1'h1;
		tgt = 16'h0F00;
		settle(1'h1, 1'h0, 1'h1, 16'hFF00);
		run = 1'h0;
		settle(1'h1, 1'h0, 1'h1, 16'hFFF8);
		$display("test brake done");
		jf = 1'h1;
		settle(1'h1, 1'h0, 1'h1, 16'h0080);
		follow = 1'h1;
		repeat (2 * TICK) @(negedge clk);
		follow = 1'h0;
		jf = 1'h0;
		settle(1'h1, 1'h0, 1'h1, 16'h0000);
		jr = 1'h1;
		settle(1'h1, 1'h0, 1'h1, 16'hFF80);
		jf = 1'h1;
		settle(1'h1, 1'h0, 1'h1, 16'h0000);
		{jf, jr} = 2'h0;
		$display("test jog done");
		load_pos(16'h0500);
		loop = 1'h1;
		cfg.current_loop = 3'h2;
		run = 1'h1;
		tgt = 16'h0500;
		settle(1'h1, 1'h1, 1'h1, 16'h0000);
		cut = 1'h1;
		settle(1'h0, 1'h0, 1'h1, 16'h0000);
		check("fb_break", status.feedback_break, 1'h1);
		cfg.emergency_output_function = 1'h1;
		settle(1'h0, 1'h0, 1'h1, 16'h1234);
		cut = 1'h0;
		cfg.current_loop = 3'h3;
		tgt = 16'h2665;
		settle(1'h0, 1'h0, 1'h1, 16'h1234);
		check("tg_break", status.target_break, 1'h1);
		tgt = 16'h2666;
		settle(1'h1, 1'h0, 1'h1, 16'hFB00);
		// Speed code still far below the loop floor
		cfg.current_loop = 3'h7;
		settle(1'h0, 1'h0, 1'h1, 16'h1234);
		check("sp_break", status.speed_break, 1'h1);
		en = 1'h0;
		settle(1'h0, 1'h0, 1'h1, 16'h1234);
		cfg.emergency_output_function = 1'h0;
		settle(1'h0, 1'h0, 1'h0, 16'h0000);
		$display("test fault done");
		{cfg.current_loop, loop} = 4'h0;
		load_pos(16'h1000);
		// Clock enable low: the new enable must not be seen
		ce = 1'h0;
		en = 1'h1;
		tgt = 16'h1400;
		repeat (3 * TICK) @(negedge clk);
		expect_out(1'h0, 1'h0, 1'h0, 16'h0000);
		ce = 1'h1;
		follow = 1'h1;
		i = 0;
		while (status.inpos !== 1'h1 && i < 60)
		begin
			repeat (TICK) @(negedge clk);
			i++;
		end
		check("reach", status.inpos, 1'h1);
		$display("test follow done");
		// Reset in mid-run; the plant returns to its load value
		follow = 1'h0;
		rst_b = 1'h0;
		repeat (2) @(negedge clk);
		rst_b = 1'h1;
		expect_out(1'h0, 1'h0, 1'h0, 16'h0000);
		settle(1'h1, 1'h0, 1'h1, 16'h0400);
		$display("test reset again done");
		conclude();
	end
endmodule : tb_aps_axis_sequencer
`default_nettype wire

//--- hw/aps_axis_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module aps_axis_sequencer
	import aps_pkg::*;
#(
	parameter int TICK_CYCLES = APS_TICK_CYCLES
)
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic enable_in,
	input wire logic run_in,
	input wire logic jog_fwd_in,
	input wire logic jog_rev_in,
	input wire logic [15:0] target_raw_in,
	input wire logic [15:0] feedback_raw_in,
	input wire logic [15:0] speed_raw_in,
	input wire aps_cfg_type cfg_in,
	output aps_valve_type valve_out,
	output aps_status_type status_out,
	output logic ready_led_out,
	output logic inpos_led_out
);

	function automatic logic [15:0] abs_diff(input logic [15:0] a,
		input logic [15:0] b);
		abs_diff = (a > b) ? (a - b) : (b - a);
	endfunction : abs_diff

	function automatic logic [15:0] sat_move(input logic [15:0] pos,
		input logic [15:0] stroke, input logic up);
		logic [16:0] sum;
		sum = {1'b0, pos} + {1'b0, stroke};
		if (up)
			sat_move = sum[16] ? APS_FULL_SCALE : sum[15:0];
		else
			sat_move = (pos > stroke) ? (pos - stroke) : 16'h0000;
	endfunction : sat_move

	function automatic logic signed [15:0] clamp(input logic signed [24:0] v,
		input logic [14:0] lim);
		logic signed [24:0] l;
		l = $signed({10'h000, lim});
		if (v > l)
			clamp = $signed({1'b0, lim});
		else if (v < -l)
			clamp = -$signed({1'b0, lim});
		else
			clamp = v[15:0];
	endfunction : clamp

	logic [APS_TICK_CNT_W-1:0] cnt_q;
	logic tick;
	logic [15:0] tgt_scaled, fb_scaled, spd_scaled;
	logic tgt_brk, fb_brk, spd_brk, sensor_fault;
	aps_state_type st_q, st_d;
	logic [15:0] tgt_q, tgt_d, act_q;
	logic signed [15:0] ctl_q, ctl_d;
	logic en_s_q, run_s_q, fault_q;
	logic jog_one;
	logic [14:0] vel_limit;
	logic signed [16:0] err;
	logic signed [24:0] prod;
	aps_valve_type valve_d;

	// Tick counter
	assign tick = ce_in && (cnt_q == APS_TICK_CNT_W'(TICK_CYCLES - 1)); // R17

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			cnt_q <= '0;
		else if (ce_in)
			cnt_q <= tick ? '0 : cnt_q + 1'b1; // R17
	end

	aps_scale u_target (
		.raw_in(target_raw_in),
		.current_loop_in(cfg_in.current_loop[APS_LOOP_TARGET]),
		.scaled_out(tgt_scaled),
		.broken_out(tgt_brk)
	);

	aps_scale u_feedback (
		.raw_in(feedback_raw_in),
		.current_loop_in(cfg_in.current_loop[APS_LOOP_FEEDBACK]),
		.scaled_out(fb_scaled),
		.broken_out(fb_brk)
	);

	aps_scale u_speed (
		.raw_in(speed_raw_in),
		.current_loop_in(cfg_in.current_loop[APS_LOOP_SPEED]),
		.scaled_out(spd_scaled),
		.broken_out(spd_brk)
	);

	assign sensor_fault = tgt_brk || fb_brk || spd_brk; // R15
	assign jog_one = jog_fwd_in ^ jog_rev_in;

	// Sequencing and target handling
	always_comb
	begin
		st_d = st_q;
		tgt_d = tgt_q;
		case (st_q)
			APS_ST_OFF:
			begin
				if (enable_in)
				begin
					tgt_d = fb_scaled; // R9
					st_d = APS_ST_HOLD;
				end
			end
			APS_ST_HOLD:
			begin
				if (run_in)
				begin
					tgt_d = tgt_scaled; // R6
					st_d = APS_ST_RUN;
				end
				else if (jog_one)
					st_d = APS_ST_JOG; // R4
			end
			APS_ST_JOG:
			begin
				// Both jogs at once count as a release
				if (run_in || !jog_one)
				begin
					tgt_d = fb_scaled; // R5
					st_d = APS_ST_HOLD;
				end
			end
			APS_ST_RUN:
			begin
				if (run_in)
					tgt_d = tgt_scaled; // R6
				else
				begin
					if (ctl_q != 16'sh0000)
						tgt_d = sat_move(fb_scaled, cfg_in.decel_stroke,
							!ctl_q[15]); // R7
					st_d = APS_ST_HOLD;
				end
			end
			default:
				st_d = APS_ST_OFF;
		endcase
		if (!enable_in)
			st_d = APS_ST_OFF;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			st_q <= APS_ST_OFF;
			tgt_q <= APS_POS_RST;
			act_q <= APS_POS_RST;
			en_s_q <= 1'b0;
			run_s_q <= 1'b0;
			fault_q <= 1'b0;
		end
		else if (tick)
		begin
			st_q <= st_d;
			tgt_q <= tgt_d;
			act_q <= fb_scaled;
			en_s_q <= enable_in;
			run_s_q <= run_in;
			fault_q <= sensor_fault;
		end
	end

	// Position controller with speed limit
	assign vel_limit = cfg_in.use_ext_speed ? spd_scaled[15:1]
		: cfg_in.max_velocity; // R10 R14
	assign err = $signed({1'b0, tgt_d}) - $signed({1'b0, fb_scaled});
	assign prod = 25'((err * $signed({1'b0, cfg_in.gain})) >>> APS_GAIN_SHIFT);

	always_comb
	begin
		ctl_d = 16'sh0000;
		if (st_d == APS_ST_JOG)
		begin
			ctl_d = clamp($signed({10'h000, cfg_in.jog_velocity}), vel_limit);
			if (jog_rev_in)
				ctl_d = -ctl_d; // R4
		end
		else if (st_d != APS_ST_OFF)
			ctl_d = clamp(prod, vel_limit); // R14
	end

	// Valve output stage
	always_comb
	begin
		valve_d = APS_VALVE_RST;
		valve_d.current_mode = (cfg_in.out_sel == APS_OUT_I_POS)
			|| (cfg_in.out_sel == APS_OUT_I_NEG); // R12
		if ((sensor_fault || !enable_in) && cfg_in.emergency_output_function)
		begin
			valve_d.active = 1'b1;
			valve_d.command = cfg_in.emergency_value; // R16
		end
		else if (enable_in)
		begin
			valve_d.active = 1'b1; // R8
			// A broken sensor with no emergency value leaves the valve centred
			if (!sensor_fault)
				valve_d.command = ((cfg_in.out_sel == APS_OUT_V_NEG)
					|| (cfg_in.out_sel == APS_OUT_I_NEG)) ? -ctl_d : ctl_d; // R12
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			ctl_q <= 16'sh0000;
			valve_out <= APS_VALVE_RST;
		end
		else if (tick)
		begin
			ctl_q <= ctl_d; // R17
			valve_out <= valve_d;
		end
	end

	// Status outputs
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			status_out <= APS_STATUS_RST;
		else if (tick)
		begin
			status_out.ready <= enable_in && !sensor_fault; // R1 R8
			status_out.inpos <= run_in && (st_d == APS_ST_RUN)
				&& (abs_diff(tgt_d, fb_scaled) <= cfg_in.inpos_window); // R2 R3
			status_out.target_break <= tgt_brk; // R15
			status_out.feedback_break <= fb_brk; // R15
			status_out.speed_break <= spd_brk; // R1
		end
	end

	assign ready_led_out = status_out.ready; // R13
	assign inpos_led_out = status_out.inpos; // R13

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	property p_ready;
		tick |=> (status_out.ready == (en_s_q && !fault_q));
	endproperty
	a_ready: assert property (p_ready) // R1
		else $error("ready does not follow enable and sensor health");

	property p_inpos_window;
		tick ##1 status_out.inpos |->
			abs_diff(tgt_q, act_q) <= cfg_in.inpos_window;
	endproperty
	a_inpos_window: assert property (p_inpos_window) // R2
		else $error("in-position shown outside the window");

	property p_inpos_run;
		tick && !run_in |=> !status_out.inpos [*2];
	endproperty
	a_inpos_run: assert property (p_inpos_run) // R3
		else $error("in-position active with run off");

	property p_jog_dir;
		tick && st_d == APS_ST_JOG && jog_fwd_in |=> ctl_q >= 16'sh0000;
	endproperty
	a_jog_dir: assert property (p_jog_dir) // R4
		else $error("forward jog drove reverse");

	property p_jog_release;
		tick && st_q == APS_ST_JOG && !jog_one && enable_in |=>
			st_q == APS_ST_HOLD && tgt_q == act_q;
	endproperty
	a_jog_release: assert property (p_jog_release) // R5
		else $error("jog release did not capture actual position");

	property p_run_follow;
		tick && enable_in && run_in && st_q == APS_ST_RUN |=>
			tgt_q == $past(tgt_scaled);
	endproperty
	a_run_follow: assert property (p_run_follow) // R6
		else $error("target not taken from external input in run");

	property p_stop_stroke;
		tick && enable_in && !run_in && st_q == APS_ST_RUN
			&& ctl_q > 16'sh0000 |=> tgt_q >= act_q && st_q == APS_ST_HOLD;
	endproperty
	a_stop_stroke: assert property (p_stop_stroke) // R7
		else $error("braking stroke not set ahead of travel");

	property p_enable_capture;
		tick && st_q == APS_ST_OFF && enable_in |=>
			tgt_q == act_q && valve_out.active;
	endproperty
	a_enable_capture: assert property (p_enable_capture) // R8 R9
		else $error("enable did not start position control");

	property p_speed_limit;
		tick |=> (ctl_q <= $signed({1'b0, $past(vel_limit)}))
			&& (ctl_q >= -$signed({1'b0, $past(vel_limit)}));
	endproperty
	a_speed_limit: assert property (p_speed_limit) // R14
		else $error("controller output exceeds velocity limit");

	property p_emergency;
		tick && cfg_in.emergency_output_function
			&& (sensor_fault || !enable_in) |=>
			valve_out.command == $past(cfg_in.emergency_value);
	endproperty
	a_emergency: assert property (p_emergency) // R16
		else $error("emergency value not applied on fault");

	property p_tick_only;
		!tick |=> $stable(valve_out) && $stable(status_out);
	endproperty
	a_tick_only: assert property (p_tick_only) // R17
		else $error("outputs changed between ticks");

	c_jog: cover property (tick && st_q == APS_ST_JOG ##[1:300] st_q == APS_ST_HOLD);
	c_inpos: cover property (status_out.inpos);
	c_stop: cover property (tick && st_q == APS_ST_RUN && !run_in && ctl_q != 16'sh0000);
	c_fault: cover property (status_out.feedback_break && valve_out.active);

endmodule : aps_axis_sequencer
`default_nettype wire

//--- hw/aps_pkg.sv
// How it works
// R1: Ready is high only with enable active and no current-loop sensor fault.
// R2: In-position drops when position error exceeds the in-position window.
// R3: In-position stays low whenever run is off.
// R4: With run off, a jog input drives the axis at jog velocity.
// R5: On jog release, target takes actual position and holding resumes.
// R6: With run on, the external target is adopted continuously.
// R7: Run dropping while moving sets target to actual plus braking stroke moving forward, actual minus braking stroke in reverse.
// R8: Enable activates the valve output and health reporting on ready.
// R9: Enable copies actual position into target and starts position control.
// R10: Speed input maps linearly from zero to full axis velocity.
// R11: Target and feedback inputs map linearly from zero to full stroke.
// R12: One setting picks valve output type and command polarity together.
// R13: Exactly two status outputs, each mirrored onto a panel indicator; status_out also carries the three break flags, which have no indicator.
// R14: Velocity is limited by internal maximum or external speed input.
// R15: Cable break on feedback and target inputs is flagged as a fault.
// R16: On fault with emergency function on, valve takes configured value.
// R17: Inputs, controller and outputs refresh once per 1 ms tick.
// R18: Current-loop code well below the 4 mA level means broken cable.
package aps_pkg;

	localparam int APS_CLK_PERIOD_NS = 100;
	localparam int APS_TICK_TIME_US = 1000;
	localparam int APS_TICK_CYCLES = (APS_TICK_TIME_US * 1000) / APS_CLK_PERIOD_NS;
	localparam int APS_TICK_CNT_W = 14;

	localparam int APS_POS_W = 16;
	localparam logic [15:0] APS_FULL_SCALE = 16'hFFFF;
	// 4 mA on a 0..20 mA converter span, and a 3 mA break level
	localparam logic [15:0] APS_LOOP_OFFSET = 16'h3333;
	localparam logic [15:0] APS_BREAK_CODE = 16'h2666;
	localparam int APS_LOOP_MUL = 5;
	localparam int APS_LOOP_SHIFT = 2;
	localparam int APS_GAIN_SHIFT = 4;

	localparam int APS_LOOP_TARGET = 0;
	localparam int APS_LOOP_FEEDBACK = 1;
	localparam int APS_LOOP_SPEED = 2;

	typedef enum logic [1:0] {
		APS_OUT_V_POS,
		APS_OUT_V_NEG,
		APS_OUT_I_POS,
		APS_OUT_I_NEG
	} aps_out_sel_type;

	typedef enum logic [1:0] {
		APS_ST_OFF,
		APS_ST_HOLD,
		APS_ST_JOG,
		APS_ST_RUN
	} aps_state_type;

	typedef struct packed {
		logic [15:0] inpos_window;
		logic [14:0] jog_velocity;
		logic [14:0] max_velocity;
		logic use_ext_speed;
		logic [15:0] decel_stroke;
		logic [7:0] gain;
		logic [2:0] current_loop;
		aps_out_sel_type out_sel;
		logic emergency_output_function;
		logic [15:0] emergency_value;
	} aps_cfg_type;

	typedef struct packed {
		logic ready;
		logic inpos;
		logic target_break;
		logic feedback_break;
		logic speed_break;
	} aps_status_type;

	typedef struct packed {
		logic active;
		logic current_mode;
		logic [15:0] command;
	} aps_valve_type;

	localparam aps_status_type APS_STATUS_RST = '0;
	localparam aps_valve_type APS_VALVE_RST = '0;
	localparam logic [15:0] APS_POS_RST = 16'h0000;

endpackage : aps_pkg

//--- hw/aps_scale.sv
`timescale 1ns/1ps
`default_nettype none
module aps_scale
	import aps_pkg::*;
(
	input wire logic [15:0] raw_in,
	input wire logic current_loop_in,
	output logic [15:0] scaled_out,
	output logic broken_out
);

	logic [18:0] span;

	always_comb
	begin
		span = 19'h00000;
		if (!current_loop_in)
		begin
			scaled_out = raw_in; // R11
		end
		else if (raw_in < APS_LOOP_OFFSET)
		begin
			scaled_out = 16'h0000;
		end
		else
		begin
			// Stretch 4..20 mA back onto the full code range
			span = 19'((19'(raw_in - APS_LOOP_OFFSET) * 19'(APS_LOOP_MUL))
				>> APS_LOOP_SHIFT); // R11
			scaled_out = (span > 19'(APS_FULL_SCALE)) ? APS_FULL_SCALE
				: span[15:0];
		end
	end

	// Voltage inputs cannot show a break, so only current loops flag it
	assign broken_out = current_loop_in && (raw_in < APS_BREAK_CODE); // R18

endmodule : aps_scale
`default_nettype wire
